// File: src/icf_pkg.sv
package icf_pkg;
	// Geometry of the direct-mapped instruction cache
	localparam int CACHE_BYTES  = 32768;
	localparam int LINE_BYTES   = 64;
	localparam int SETS         = CACHE_BYTES / LINE_BYTES;
	localparam int LINE_WORDS   = 16;
	localparam int BUNDLE_WORDS = 4;
	localparam int WORD_W       = 32;
	localparam int SET_W        = 9;
	localparam int OFF_W        = 4;
	localparam int TAG_W        = 19;
	localparam int MEM_W        = SET_W + OFF_W;
	localparam int SCAN_W       = 7;
	localparam int QUAD_W       = 2;
	// Virtual address fields
	localparam int OFF_LSB      = 2;
	localparam int OFF_MSB      = 5;
	localparam int SET_LSB      = 6;
	localparam int SET_MSB      = 14;
	localparam int LOW_MSB      = 12;
	localparam int TAG_LSB      = 13;
	localparam int TAG_MSB      = 31;
	localparam int QUAD_LSB     = 13;
	localparam int QUAD_MSB     = 14;
	// Sized constants
	localparam logic [4:0]        LINE_WORDS_C = 5'h10;
	localparam logic [2:0]        BUNDLE_C     = 3'h4;
	localparam logic [OFF_W-1:0]  LAST_WORD    = 4'hf;
	localparam logic [SCAN_W-1:0] SCAN_LAST    = 7'h7f;
	localparam logic [1:0]        BYTE_ZERO    = 2'h0;
	localparam logic [5:0]        LINE_ZERO    = 6'h00;
	// Controller states, Gray coded along lookup, request, fill
	typedef enum logic [1:0] {
		ICF_LOOKUP    = 2'h0,
		ICF_FILL_REQ  = 2'h1,
		ICF_FILL      = 2'h3,
		ICF_PAGE_SCAN = 2'h2
	} icf_state_t;
endpackage

// File: src/icf_top.sv
`timescale 1ns/100ps
// How it works
// R01: Buffer keeps looking up bundles ahead whenever its slot is free.
// R02: Taken branch empties the buffer and restarts fetch at the target.
// R03: Bundle within one line arrives one lookup cycle after a branch.
// R04: Bundle crossing two lines takes two lookup cycles after a branch.
// R05: Every fetch goes through the cache; no uncached fetch path exists.
// R06: Direct mapped, 32 Kbyte, 512 sets of one 64-byte line.
// R07: Virtual bits 5:2 pick the word, bits 14:6 pick the set.
// R08: Translated bits 31:13 form the tag compared for a hit.
// R09: Each answer carries up to four 32-bit words, 16 bytes.
// R10: Miss fills the line from memory while stalled, then delivers the bundle.
// R11: Whole-cache invalidate clears every line valid bit.
// R12: Stream synchronise empties the buffer so refetch uses the cleaned cache.
// R13: Whole, synchronise and page invalidate act only in supervisor mode.
// R14: Page invalidate address is base plus offset, purging one 8 Kbyte page.
// R15: Address bits 31:13 give the page, bits 14:13 pick the scanned quadrant.
// R16: Software should supply all 13 low virtual bits in the page address.
// R17: Software issues one page invalidate per distinct virtual mapping.
// R18: Self-modifying code must invalidate the cache before running new code.
// R19: Fill bus error raises the fetch exception when that bundle executes.
// R20: Fill bus error leaves the affected line invalid.
// R21: Fill is one aligned 64-byte request; valid only after clean data.
module icf_top import icf_pkg::*; (
	// Clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  reset,
	// Core control
	input  wire logic                  branch_taken,
	input  wire logic                  sync_req,
	input  wire logic [31:0]           redirect_addr,
	input  wire logic                  supervisor,
	input  wire logic                  inv_all_req,
	input  wire logic                  inv_page_req,
	input  wire logic [31:0]           inv_page_base,
	input  wire logic [31:0]           inv_page_offset,
	output logic                       maint_ready,
	// Bundle issue
	output logic                       issue_valid,
	input  wire logic                  issue_ready,
	output logic [127:0]               issue_bundle,
	output logic [31:0]                issue_addr,
	output logic                       issue_error,
	output logic                       core_stall,
	output logic                       fetch_bus_error_exception,
	// Translation
	output logic [31:0]                xlat_vaddr,
	input  wire logic [TAG_W-1:0]      xlat_ppn,
	// Core memory controller
	output logic                       fill_req_valid,
	input  wire logic                  fill_req_ready,
	output logic [31:0]                fill_req_addr,
	input  wire logic                  fill_data_valid,
	input  wire logic [31:0]           fill_data,
	input  wire logic                  fill_data_error
);

	icf_state_t                state_ff;
	logic [31:0]               fa_ff;
	logic [31:0]               start_ff;
	logic [2:0]                got_ff;
	logic [WORD_W-1:0]         gather_ff [BUNDLE_WORDS];
	logic                      buf_valid_ff;
	logic                      buf_err_ff;
	logic [127:0]              buf_data_ff;
	logic [31:0]               buf_addr_ff;
	logic                      exc_ff;
	logic [SETS-1:0]           line_valid_ff; // R06
	logic [TAG_W-1:0]          tag_mem [SETS];
	logic [WORD_W-1:0]         line_mem [SETS*LINE_WORDS];
	logic [SET_W-1:0]          fill_set_ff;
	logic [TAG_W-1:0]          fill_tag_ff;
	logic [OFF_W-1:0]          fill_cnt_ff;
	logic                      fill_err_ff;
	logic                      fill_stale_ff;
	logic [TAG_W-1:0]          pg_tag_ff;
	logic [QUAD_W-1:0]         pg_quad_ff;
	logic [SCAN_W-1:0]         scan_cnt_ff;
	logic                      redirect;
	logic                      pg_go;
	logic                      all_go;
	logic                      lookup_go;
	logic                      hit;
	logic                      hit_go;
	logic                      miss_go;
	logic                      done_bundle;
	logic                      fill_beat;
	logic                      fill_last;
	logic                      fill_bad;
	logic                      scan_hit;
	logic [31:0]               page_ea;
	logic [SET_W-1:0]          cur_set;
	logic [SET_W-1:0]          scan_set;
	logic [OFF_W-1:0]          cur_off;
	logic [4:0]                avail;
	logic [2:0]                room;
	logic [2:0]                n_take;
	logic [WORD_W-1:0]         nxt_word [BUNDLE_WORDS];

	// Control decode
	assign redirect    = branch_taken | (sync_req & supervisor);      // R02 R12 R13
	assign maint_ready = (state_ff == ICF_LOOKUP);
	assign pg_go       = maint_ready & inv_page_req & supervisor;     // R13
	assign all_go      = maint_ready & inv_all_req & supervisor;      // R13
	assign lookup_go   = maint_ready & (~buf_valid_ff | issue_ready)
		& ~redirect & ~pg_go & ~all_go;                           // R01
	assign cur_set     = fa_ff[SET_MSB:SET_LSB];                      // R07
	assign cur_off     = fa_ff[OFF_MSB:OFF_LSB];                      // R07
	assign hit         = line_valid_ff[cur_set]
		& (tag_mem[cur_set] == xlat_ppn);                         // R05 R08
	assign hit_go      = lookup_go & hit;
	assign miss_go     = lookup_go & ~hit;                            // R10
	assign avail       = LINE_WORDS_C - {1'b0, cur_off};
	assign room        = BUNDLE_C - got_ff;
	assign n_take      = (avail < {2'b00, room}) ? avail[2:0] : room; // R04 R09
	assign done_bundle = hit_go & ((got_ff + n_take) == BUNDLE_C);     // R03 R04
	assign fill_beat   = (state_ff == ICF_FILL) & fill_data_valid;
	assign fill_last   = fill_beat & (fill_cnt_ff == LAST_WORD);
	assign fill_bad    = fill_last & (fill_err_ff | fill_data_error);
	assign page_ea     = inv_page_base + inv_page_offset;             // R14
	assign scan_set    = {pg_quad_ff, scan_cnt_ff};                   // R15
	assign scan_hit    = (state_ff == ICF_PAGE_SCAN) & line_valid_ff[scan_set]
		& (tag_mem[scan_set] == pg_tag_ff);                       // R14 R15

	// Outputs
	assign issue_valid    = buf_valid_ff;
	assign issue_bundle   = buf_data_ff;
	assign issue_addr     = buf_addr_ff;
	assign issue_error    = buf_err_ff;
	assign core_stall     = ~buf_valid_ff;                            // R03 R04 R10
	assign fetch_bus_error_exception = exc_ff;
	assign xlat_vaddr     = fa_ff;
	assign fill_req_valid = (state_ff == ICF_FILL_REQ);
	assign fill_req_addr  = {fill_tag_ff, fill_set_ff[LOW_MSB-SET_LSB:0], LINE_ZERO}; // R21

	// Word lanes of the bundle under assembly
	for (genvar j = 0; j < BUNDLE_WORDS; j++) begin : g_lane
		logic [2:0] rel;
		logic       take;
		assign rel  = 3'(j) - got_ff;
		assign take = (3'(j) >= got_ff) && (rel < n_take);
		assign nxt_word[j] = take
			? line_mem[{cur_set, cur_off + OFF_W'(rel)}] : gather_ff[j]; // R09
	end

	// Controller state
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state_ff <= ICF_LOOKUP;
		end else begin
			case (state_ff)
				ICF_LOOKUP: begin
					if (pg_go) begin
						state_ff <= ICF_PAGE_SCAN;
					end else if (miss_go) begin
						state_ff <= ICF_FILL_REQ;                 // R10
					end
				end
				ICF_FILL_REQ: begin
					if (fill_req_ready) begin
						state_ff <= ICF_FILL;
					end
				end
				ICF_FILL: begin
					if (fill_last) begin
						state_ff <= ICF_LOOKUP;
					end
				end
				default: begin
					if (scan_cnt_ff == SCAN_LAST) begin
						state_ff <= ICF_LOOKUP;
					end
				end
			endcase
		end
	end

	// Fetch address and bundle assembly
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			fa_ff    <= 32'h0000_0000;
			start_ff <= 32'h0000_0000;
			got_ff   <= 3'h0;
			for (int i = 0; i < BUNDLE_WORDS; i++) begin
				gather_ff[i] <= 32'h0000_0000;
			end
		end else if (redirect) begin
			fa_ff  <= {redirect_addr[31:OFF_LSB], BYTE_ZERO};        // R02
			got_ff <= 3'h0;
		end else if (hit_go) begin
			fa_ff  <= fa_ff + 32'({n_take, BYTE_ZERO});              // R01 R04
			got_ff <= done_bundle ? 3'h0 : got_ff + n_take;
			if (got_ff == 3'h0) begin
				start_ff <= fa_ff;
			end
			for (int i = 0; i < BUNDLE_WORDS; i++) begin
				gather_ff[i] <= nxt_word[i];
			end
		end
	end

	// Bundle buffer toward the core
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			buf_valid_ff <= 1'b0;
			buf_err_ff   <= 1'b0;
			buf_data_ff  <= 128'h0;
			buf_addr_ff  <= 32'h0000_0000;
		end else if (redirect) begin
			buf_valid_ff <= 1'b0;                                     // R02 R12
			buf_err_ff   <= 1'b0;
		end else if (fill_bad && !fill_stale_ff) begin
			buf_valid_ff <= 1'b1;                                     // R19
			buf_err_ff   <= 1'b1;
			buf_addr_ff  <= (got_ff == 3'h0) ? fa_ff : start_ff;
		end else if (done_bundle) begin
			buf_valid_ff <= 1'b1;                                     // R03 R10
			buf_err_ff   <= 1'b0;
			buf_data_ff  <= {nxt_word[3], nxt_word[2], nxt_word[1], nxt_word[0]};
			buf_addr_ff  <= (got_ff == 3'h0) ? fa_ff : start_ff;
		end else if (issue_ready) begin
			buf_valid_ff <= 1'b0;
			buf_err_ff   <= 1'b0;
		end
	end

	// Fetch bus error raised as the faulty bundle is executed
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			exc_ff <= 1'b0;
		end else begin
			exc_ff <= buf_valid_ff & issue_ready & buf_err_ff;        // R19
		end
	end

	// Line valid bits
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			line_valid_ff <= '0;
		end else if (all_go) begin
			line_valid_ff <= '0;                                      // R11
		end else if (miss_go) begin
			line_valid_ff[cur_set] <= 1'b0;
		end else if (fill_last) begin
			line_valid_ff[fill_set_ff] <= ~fill_bad;                  // R20 R21
		end else if (scan_hit) begin
			line_valid_ff[scan_set] <= 1'b0;                          // R14
		end
	end

	// Tag and data arrays
	always_ff @(posedge clk_sys) begin
		if (fill_beat) begin
			line_mem[{fill_set_ff, fill_cnt_ff}] <= fill_data;        // R10
		end
		if (fill_last) begin
			tag_mem[fill_set_ff] <= fill_tag_ff;                      // R08
		end
	end

	// Line fill tracking
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			fill_set_ff   <= '0;
			fill_tag_ff   <= '0;
			fill_cnt_ff   <= '0;
			fill_err_ff   <= 1'b0;
			fill_stale_ff <= 1'b0;
		end else if (miss_go) begin
			fill_set_ff   <= cur_set;
			fill_tag_ff   <= xlat_ppn;                                // R08
			fill_cnt_ff   <= '0;
			fill_err_ff   <= 1'b0;
			fill_stale_ff <= 1'b0;
		end else begin
			if (fill_beat) begin
				fill_cnt_ff <= fill_cnt_ff + 4'h1;
				fill_err_ff <= fill_err_ff | fill_data_error;     // R20
			end
			if (redirect && !maint_ready) begin
				fill_stale_ff <= 1'b1;
			end
		end
	end

	// Page invalidate quadrant scan
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			pg_tag_ff   <= '0;
			pg_quad_ff  <= '0;
			scan_cnt_ff <= '0;
		end else if (pg_go) begin
			pg_tag_ff   <= page_ea[TAG_MSB:TAG_LSB];                  // R15
			pg_quad_ff  <= page_ea[QUAD_MSB:QUAD_LSB];                // R15
			scan_cnt_ff <= '0;
		end else if (state_ff == ICF_PAGE_SCAN) begin
			scan_cnt_ff <= scan_cnt_ff + 7'h01;
		end
	end

	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	flush_branch_a: assert property (branch_taken |=> !issue_valid) // R02
		else $error("buffer not emptied by branch");
	one_cycle_a: assert property (branch_taken ##1 (done_bundle && got_ff == 3'h0)
		|=> issue_valid && issue_addr == $past(fa_ff)) // R03
		else $error("single line bundle late");
	split_two_a: assert property (branch_taken ##1 (hit_go && !done_bundle) ##1 hit_go // R04
		|-> !issue_valid ##1 (issue_valid && issue_addr == $past(start_ff)))
		else $error("split bundle timing wrong");
	miss_fill_a: assert property (miss_go |=> fill_req_valid && core_stall) // R10
		else $error("miss did not request fill");
	fill_align_a: assert property (fill_req_valid |-> fill_req_addr[5:0] == LINE_ZERO) // R21
		else $error("fill request not line aligned");
	err_invalid_a: assert property (fill_bad |=> !line_valid_ff[$past(fill_set_ff)]) // R20
		else $error("errored line left valid");
	clean_valid_a: assert property (fill_last && !fill_bad
		|=> line_valid_ff[$past(fill_set_ff)]) // R21
		else $error("clean fill not marked valid");
	inv_all_a: assert property (all_go |=> line_valid_ff == '0) // R11
		else $error("whole invalidate missed a line");
	priv_gate_a: assert property (!supervisor && maint_ready
		|=> state_ff != ICF_PAGE_SCAN) // R13
		else $error("page invalidate in user mode");
	page_scan_a: assert property (pg_go |-> ##128 (state_ff == ICF_PAGE_SCAN)
		##1 (state_ff == ICF_LOOKUP)) // R14
		else $error("page scan length wrong");
	bus_exc_a: assert property (issue_valid && issue_ready && issue_error
		|=> fetch_bus_error_exception) // R19
		else $error("fetch bus error not raised");

	split_seen_c: cover property (hit_go && !done_bundle ##1 done_bundle);
	fill_err_c:   cover property (fill_bad ##[1:4] fetch_bus_error_exception);
	page_hit_c:   cover property (scan_hit);
	sync_c:       cover property (sync_req && supervisor && buf_valid_ff);

endmodule // icf_top

// File: tb/icf_mem_model.sv
`timescale 1ns/100ps
module icf_mem_model import icf_pkg::*; (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             reset,
	// Memory controller and translation side
	input  wire logic             fill_req_valid,
	output logic                  fill_req_ready,
	input  wire logic [31:0]      fill_req_addr,
	output logic                  fill_data_valid,
	output logic [31:0]           fill_data,
	output logic                  fill_data_error,
	input  wire logic [31:0]      xlat_vaddr,
	output logic [TAG_W-1:0]      xlat_ppn,
	// Bench control and observation
	input  wire logic             slow,
	input  wire logic             inject_err,
	output logic [31:0]           last_addr,
	output int                    fills
);
	// Identity page mapping
	assign xlat_ppn = xlat_vaddr[TAG_MSB:TAG_LSB];
	initial begin
		fill_req_ready  = 1'b0;
		fill_data_valid = 1'b0;
		fill_data_error = 1'b0;
		fill_data       = 32'h5a5a_5a5a;
		fills           = 0;
	end
	// One line fill, sixteen beats, driven on the falling edge
	always @(negedge clk_sys) if (fill_req_valid === 1'b1 && reset === 1'b0) begin
		if (slow) repeat (3) @(negedge clk_sys);
		last_addr      = fill_req_addr;
		fill_req_ready = 1'b1;
		@(negedge clk_sys);
		fills++;
		fill_req_ready = 1'b0;
		for (int k = 0; k < 16; k++) begin
			fill_data_valid = 1'b1;
			fill_data       = (last_addr + 32'(4 * k)) ^ 32'h5a5a_0000;
			fill_data_error = inject_err && k == 5;
			@(negedge clk_sys);
		end
		fill_data_valid = 1'b0;
		fill_data       = ~fill_data;
		fill_data_error = 1'b0;
	end
endmodule // icf_mem_model

// File: tb/testbench.sv
`timescale 1ns/100ps
module testbench import icf_pkg::*;;
	localparam logic [31:0] ADDR_A = 32'h0000_2000;
	localparam logic [31:0] ADDR_C = 32'h0000_4000;
	logic             clk_sys = 1'b0, reset = 1'b1, supervisor = 1'b0, slow = 1'b0;
	logic             branch_taken = 1'b0, sync_req = 1'b0, issue_ready = 1'b0, inject_err = 1'b0;
	logic             inv_all_req = 1'b0, inv_page_req = 1'b0;
	logic [31:0]      redirect_addr = 32'h0, inv_page_base = 32'h0, inv_page_offset = 32'h0;
	logic             maint_ready, issue_valid, issue_error, core_stall, fetch_bus_error_exception;
	logic             fill_req_valid, fill_req_ready, fill_data_valid, fill_data_error;
	logic [127:0]     issue_bundle;
	logic [31:0]      issue_addr, xlat_vaddr, fill_req_addr, fill_data, last_addr;
	logic [TAG_W-1:0] xlat_ppn;
	int               fills, failures = 0, checked = 0;
	always #12.5 clk_sys = ~clk_sys;
	icf_top i_dut (.clk_sys, .reset, .branch_taken, .sync_req, .redirect_addr, .supervisor,
		.inv_all_req, .inv_page_req, .inv_page_base, .inv_page_offset, .maint_ready,
		.issue_valid, .issue_ready, .issue_bundle, .issue_addr, .issue_error, .core_stall,
		.fetch_bus_error_exception, .xlat_vaddr, .xlat_ppn, .fill_req_valid, .fill_req_ready,
		.fill_req_addr, .fill_data_valid, .fill_data, .fill_data_error);
	icf_mem_model i_mem (.clk_sys, .reset, .fill_req_valid, .fill_req_ready, .fill_req_addr,
		.fill_data_valid, .fill_data, .fill_data_error, .xlat_vaddr, .xlat_ppn, .slow,
		.inject_err, .last_addr, .fills);
	task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tally_and_finish();
		$display("Comparisons %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic redirect(logic [31:0] a, logic via_sync);
		redirect_addr = a;
		branch_taken  = !via_sync;
		sync_req      = via_sync;
		@(negedge clk_sys);
		branch_taken  = 1'b0;
		sync_req      = 1'b0;
	endtask
	task automatic settle();
		for (int n = 0; issue_valid !== 1'b1 || maint_ready !== 1'b1; n++) begin
			if (n == 600) begin
				cmp("settle timeout", 32'h0, 32'h1);
				tally_and_finish();
			end
			@(negedge clk_sys);
		end
	endtask
	task automatic check_bundle(logic [31:0] a);
		cmp("issue_addr", a, issue_addr);
		for (int i = 0; i < 4; i++) begin
			cmp("issue_bundle", (a + 32'(4 * i)) ^ 32'h5a5a_0000, issue_bundle[32*i +: 32]);
		end
	endtask
	task automatic s_fill(logic [31:0] a);
		int f;
		f = fills;
		redirect(a, 1'b0);
		settle();
		check_bundle(a);
		cmp("fill_req_addr", {a[31:6], 6'h00}, last_addr);
		cmp("fill count", 32'(f + 1), 32'(fills));
	endtask
	task automatic s_hit(logic [31:0] a, int stall);
		int f;
		f = fills;
		redirect(a, 1'b0);
		repeat (stall) begin
			cmp("core_stall", 32'h1, 32'(core_stall));
			@(negedge clk_sys);
		end
		cmp("issue_valid", 32'h1, 32'(issue_valid));
		check_bundle(a);
		cmp("fill count", 32'(f), 32'(fills));
	endtask
	task automatic s_maint(logic priv);
		int f;
		supervisor      = priv;
		inv_page_base   = ADDR_A;
		inv_page_offset = 32'h0000_0000;
		inv_all_req     = 1'b1;
		inv_page_req    = 1'b1;
		@(negedge clk_sys);
		inv_all_req     = 1'b0;
		inv_page_req    = 1'b0;
		f = fills;
		redirect(ADDR_A, 1'b1);
		cmp("issue_valid", 32'(!priv), 32'(issue_valid));
		settle();
		check_bundle(ADDR_A);
		cmp("fill count", 32'(f + int'(priv)), 32'(fills));
	endtask
	task automatic s_page();
		int n;
		inv_page_base   = ADDR_A - 32'h0000_0100;
		inv_page_offset = 32'h0000_0100;
		inv_page_req    = 1'b1;
		@(negedge clk_sys);
		inv_page_req    = 1'b0;
		for (n = 0; maint_ready !== 1'b1 && n < 300; n++) begin
			@(negedge clk_sys);
		end
		cmp("scan cycles", 32'h0000_0080, 32'(n));
		if (n == 300) begin
			tally_and_finish();
		end
		s_hit(32'h0, 1);
		slow = 1'b1;
		s_fill(ADDR_A);
		slow = 1'b0;
	endtask
	task automatic s_error();
		int f, hits;
		inject_err = 1'b1;
		redirect(ADDR_C, 1'b0);
		settle();
		inject_err = 1'b0;
		cmp("issue_error", 32'h1, 32'(issue_error));
		f = fills;
		issue_ready = 1'b1;
		@(negedge clk_sys);
		issue_ready = 1'b0;
		hits = int'(fetch_bus_error_exception === 1'b1);
		@(negedge clk_sys);
		hits += int'(fetch_bus_error_exception === 1'b1);
		cmp("exception pulses", 32'h1, 32'(hits));
		settle();
		cmp("issue_error", 32'h0, 32'(issue_error));
		check_bundle(ADDR_C);
		cmp("fill count", 32'(f + 1), 32'(fills));
	endtask
	initial begin
		repeat (4) @(negedge clk_sys);
		reset = 1'b0;
		settle();
		s_fill(ADDR_A);
		issue_ready = 1'b1;
		@(negedge clk_sys);
		issue_ready = 1'b0;
		settle();
		check_bundle(ADDR_A + 32'h0000_0010);
		s_fill(ADDR_A + 32'h0000_0040);
		s_hit(ADDR_A + 32'h0000_0034, 2);
		s_hit(ADDR_A, 1);
		s_maint(1'b0);
		s_hit(ADDR_A, 1);
		s_maint(1'b1);
		s_fill(32'h0);
		s_page();
		s_error();
		tally_and_finish();
	end
endmodule // testbench
